// file: inc/dpr_pkg.sv
/*
 * shared types, widths and the lane decode of the dual-port memory.
 * assumes: one system clock; port pins arrive from outside its domain.
 */
package dpr_pkg;

    ////////////////////////////////////////////////////////////////////////
    // sizes of the array and of the port buses
    localparam int ADDR_W     = 14;
    localparam int DATA_W     = 32;
    localparam int PAR_W      = 4;
    localparam int TOTAL_BITS = 18432;
    localparam int WORD_BITS  = DATA_W + PAR_W;
    localparam int WORDS      = TOTAL_BITS / WORD_BITS;
    localparam int WORD_IDX_W = 9;

    ////////////////////////////////////////////////////////////////////////
    // aspect ratio of a port: depth by width
    typedef enum logic [2:0] {
        DPR_W1  = 3'h0,
        DPR_W2  = 3'h1,
        DPR_W4  = 3'h2,
        DPR_W9  = 3'h3,
        DPR_W18 = 3'h4,
        DPR_W36 = 3'h5
    } dpr_width_t;

    // pins of one port as seen at the block edge
    typedef struct packed {
        logic                  clk;
        logic                  en;
        logic                  we;
        logic                  sync_output_reset;
        logic [ADDR_W-1:0]     addr;
        logic [DATA_W-1:0]     din;
        logic [PAR_W-1:0]      pin;
    } dpr_port_in_t;

    // static setting of one port
    typedef struct packed {
        logic                  inv_clk;
        logic                  inv_en;
        logic                  inv_we;
        logic                  inv_rst;
        dpr_width_t            width;
        logic [DATA_W-1:0]     init_data;
        logic [PAR_W-1:0]      init_par;
    } dpr_port_cfg_t;

    // read data of one port
    typedef struct packed {
        logic [DATA_W-1:0]     data;
        logic [PAR_W-1:0]      par;
    } dpr_rd_t;

    // where an address lands inside a 36-bit word
    typedef struct packed {
        logic [WORD_IDX_W-1:0] word;
        logic [4:0]            doff;
        logic [1:0]            poff;
        logic [DATA_W-1:0]     dmask;
        logic [PAR_W-1:0]      pmask;
    } dpr_lane_t;

    localparam dpr_rd_t RD_RESET = '0;

    ////////////////////////////////////////////////////////////////////////
    // decode width and address into word index, offsets and lane masks
    function automatic dpr_lane_t lane_decode(dpr_width_t w,
                                              logic [ADDR_W-1:0] a);
        dpr_lane_t l;
        l = '0;
        case (w)
            DPR_W1: begin
                l.word  = a[13:5];
                l.doff  = a[4:0];
                l.dmask = 32'h0000_0001;
            end
            DPR_W2: begin
                l.word  = a[12:4];
                l.doff  = {a[3:0], 1'b0};
                l.dmask = 32'h0000_0003;
            end
            DPR_W4: begin
                l.word  = a[11:3];
                l.doff  = {a[2:0], 2'h0};
                l.dmask = 32'h0000_000F;
            end
            DPR_W9: begin
                l.word  = a[10:2];
                l.doff  = {a[1:0], 3'h0};
                l.dmask = 32'h0000_00FF;
                l.poff  = a[1:0];
                l.pmask = 4'h1;
            end
            DPR_W18: begin
                l.word  = a[9:1];
                l.doff  = {a[0], 4'h0};
                l.dmask = 32'h0000_FFFF;
                l.poff  = {a[0], 1'b0};
                l.pmask = 4'h3;
            end
            DPR_W36: begin
                l.word  = a[8:0];
                l.dmask = 32'hFFFF_FFFF;
                l.pmask = 4'hF;
            end
            default: l = '0;
        endcase
        return l;
    endfunction

endpackage

// file: rtl/dpr_port_sync.sv
/*
 * samples the pins of one memory port through three flip-flops and
 * reports each active edge of the port clock with the bundle held.
 * assumes: port pins are asynchronous to clk_sys and much slower.
 */
module dpr_port_sync (
    input  wire logic                 clk_sys,
    input  wire logic                 arst_n,
    input  wire logic                 clk_inv,
    input  wire dpr_pkg::dpr_port_in_t pins,
    output logic                      edge_pulse,
    output dpr_pkg::dpr_port_in_t     held
);

    typedef struct packed {
        dpr_pkg::dpr_port_in_t s1;
        dpr_pkg::dpr_port_in_t s2;
        dpr_pkg::dpr_port_in_t s3;
        dpr_pkg::dpr_port_in_t hold;
        logic                  level;
        logic                  ev;
    } dpr_sync_t;

    dpr_sync_t q;
    dpr_sync_t next_q;

    ////////////////////////////////////////////////////////////////////////
    // a clock change counts once stages two and three agree
    always_comb begin
        next_q    = q;
        next_q.s1 = pins;
        next_q.s2 = q.s1;
        next_q.s3 = q.s2;
        next_q.ev = 1'b0;
        if (q.s2.clk == q.s3.clk && q.s2.clk != q.level) begin
            next_q.level = q.s2.clk;
            next_q.ev    = q.s2.clk ^ clk_inv;
            next_q.hold  = q.s3;
        end
    end

    // state register
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            q <= '0;
        end else begin
            q <= next_q;
        end
    end

    assign edge_pulse = q.ev;
    assign held       = q.hold;

    ////////////////////////////////////////////////////////////////////////
    // an edge is reported one cycle after two stable samples
    property p_edge_stable;
        @(posedge clk_sys) disable iff (!arst_n)
        q.ev |-> $past(q.s2.clk) == $past(q.s3.clk);
    endproperty
    a_edge_stable: assert property (p_edge_stable)
        else $error("edge reported from unsettled clock samples");

    // the reported edge matches the configured polarity
    property p_edge_polarity;
        @(posedge clk_sys) disable iff (!arst_n)
        q.ev |-> (q.level ^ clk_inv) && $changed(q.level);
    endproperty
    a_edge_polarity: assert property (p_edge_polarity)
        else $error("edge reported on the inactive clock transition");

endmodule // dpr_port_sync

// file: rtl/dpr_ram.sv
/*
 * true dual-port memory of 18 Kbit with two independent ports of
 * configurable width, polarity and output reset value.
 * assumes: port pins come from user logic outside clk_sys, each port
 * clock well below clk_sys / 4; configuration stays static in use.
 */

module dpr_ram (
    input  wire logic                  clk_sys,
    input  wire logic                  arst_n,
    input  wire dpr_pkg::dpr_port_cfg_t porta_cfg,
    input  wire dpr_pkg::dpr_port_cfg_t portb_cfg,
    input  wire dpr_pkg::dpr_port_in_t  porta_pins,
    input  wire dpr_pkg::dpr_port_in_t  portb_pins,
    output dpr_pkg::dpr_rd_t           porta_rd,
    output dpr_pkg::dpr_rd_t           portb_rd
);

    typedef struct packed {
        dpr_pkg::dpr_rd_t a;
        dpr_pkg::dpr_rd_t b;
    } dpr_state_t;

    dpr_state_t            q;
    dpr_state_t            next_q;
    logic                  ev_a;
    logic                  ev_b;
    dpr_pkg::dpr_port_in_t in_a;
    dpr_pkg::dpr_port_in_t in_b;
    dpr_pkg::dpr_lane_t    ln_a;
    dpr_pkg::dpr_lane_t    ln_b;
    logic                  en_a;
    logic                  en_b;
    logic                  wr_a;
    logic                  wr_b;
    logic                  rs_a;
    logic                  rs_b;
    dpr_pkg::dpr_rd_t      rd_a;
    dpr_pkg::dpr_rd_t      rd_b;
    dpr_pkg::dpr_rd_t      word_a;
    dpr_pkg::dpr_rd_t      word_b;

    // storage: 512 words of 32 data and 4 parity bits
    logic [dpr_pkg::DATA_W-1:0] mem_data [0:dpr_pkg::WORDS-1];
    logic [dpr_pkg::PAR_W-1:0]  mem_par  [0:dpr_pkg::WORDS-1];

    ////////////////////////////////////////////////////////////////////////
    // pick the lane of a word that the address selects
    function automatic dpr_pkg::dpr_rd_t extract(dpr_pkg::dpr_rd_t w,
                                                 dpr_pkg::dpr_lane_t l);
        dpr_pkg::dpr_rd_t r;
        r.data = (w.data >> l.doff) & l.dmask;
        r.par  = (w.par >> l.poff) & l.pmask;
        return r;
    endfunction

    // merge write data into the lane of a word
    function automatic dpr_pkg::dpr_rd_t merge(dpr_pkg::dpr_rd_t w,
                                               dpr_pkg::dpr_lane_t l,
                                               dpr_pkg::dpr_port_in_t p);
        dpr_pkg::dpr_rd_t r;
        r.data = (w.data & ~(l.dmask << l.doff))
               | ((p.din & l.dmask) << l.doff);
        r.par  = (w.par & ~(l.pmask << l.poff))
               | ((p.pin & l.pmask) << l.poff);
        return r;
    endfunction

    // configured output reset value cut to the port width
    function automatic dpr_pkg::dpr_rd_t init_val(dpr_pkg::dpr_port_cfg_t c);
        dpr_pkg::dpr_rd_t   r;
        dpr_pkg::dpr_lane_t l;
        l      = dpr_pkg::lane_decode(c.width, '0);
        r.data = c.init_data & l.dmask;
        r.par  = c.init_par & l.pmask;
        return r;
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // pin sampling and edge detection per port
    dpr_port_sync u_sync_a (
        .clk_sys    (clk_sys),
        .arst_n     (arst_n),
        .clk_inv    (porta_cfg.inv_clk),
        .pins       (porta_pins),
        .edge_pulse (ev_a),
        .held       (in_a)
    );

    dpr_port_sync u_sync_b (
        .clk_sys    (clk_sys),
        .arst_n     (arst_n),
        .clk_inv    (portb_cfg.inv_clk),
        .pins       (portb_pins),
        .edge_pulse (ev_b),
        .held       (in_b)
    );

    ////////////////////////////////////////////////////////////////////////
    // control polarity and lane decode per port
    always_comb begin
        en_a = in_a.en ^ porta_cfg.inv_en;
        en_b = in_b.en ^ portb_cfg.inv_en;
        wr_a = ev_a && en_a && (in_a.we ^ porta_cfg.inv_we);
        wr_b = ev_b && en_b && (in_b.we ^ portb_cfg.inv_we);
        rs_a = in_a.sync_output_reset ^ porta_cfg.inv_rst;
        rs_b = in_b.sync_output_reset ^ portb_cfg.inv_rst;
        ln_a = dpr_pkg::lane_decode(porta_cfg.width, in_a.addr);
        ln_b = dpr_pkg::lane_decode(portb_cfg.width, in_b.addr);
    end

    // old contents seen by each port, before this edge's writes
    always_comb begin
        rd_a = extract({mem_data[ln_a.word], mem_par[ln_a.word]}, ln_a);
        rd_b = extract({mem_data[ln_b.word], mem_par[ln_b.word]}, ln_b);
    end

    // new word values; port b lands on top of port a in a shared word
    always_comb begin
        word_a = merge({mem_data[ln_a.word], mem_par[ln_a.word]},
                       ln_a, in_a);
        word_b = merge({mem_data[ln_b.word], mem_par[ln_b.word]},
                       ln_b, in_b);
        if (wr_a && ln_a.word == ln_b.word) begin
            word_b = merge(word_a, ln_b, in_b);
        end
    end

    // array write, no reset on the storage
    always_ff @(posedge clk_sys) begin
        if (wr_a) begin
            mem_data[ln_a.word] <= word_a.data;
            mem_par[ln_a.word]  <= word_a.par;
        end
        if (wr_b) begin
            mem_data[ln_b.word] <= word_b.data;
            mem_par[ln_b.word]  <= word_b.par;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // read registers update only on an enabled edge
    always_comb begin
        next_q = q;
        if (ev_a && en_a) begin
            next_q.a = rs_a ? init_val(porta_cfg) : rd_a;
        end
        if (ev_b && en_b) begin
            next_q.b = rs_b ? init_val(portb_cfg) : rd_b;
        end
    end

    // state register
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            q <= '{a: dpr_pkg::RD_RESET, b: dpr_pkg::RD_RESET};
        end else begin
            q <= next_q;
        end
    end

    assign porta_rd = q.a;
    assign portb_rd = q.b;

    ////////////////////////////////////////////////////////////////////////
    // read data of port a changes only after one of its edges
    property p_rd_after_edge;
        @(posedge clk_sys) disable iff (!arst_n)
        $changed(q.a) |-> $past(ev_a);
    endproperty
    a_rd_after_edge: assert property (p_rd_after_edge)
        else $error("port a read data moved without a clock edge");

    // a disabled edge leaves port b read data as it was
    property p_hold_disabled;
        @(posedge clk_sys) disable iff (!arst_n)
        (ev_b && !en_b) |=> $stable(q.b);
    endproperty
    a_hold_disabled: assert property (p_hold_disabled)
        else $error("port b read data changed with enable inactive");

    // a disabled edge leaves the addressed word of port a untouched
    property p_no_write_disabled;
        @(posedge clk_sys) disable iff (!arst_n)
        (ev_a && !en_a && !wr_b)
            |=> mem_data[$past(ln_a.word)] == $past(mem_data[ln_a.word])
                && mem_par[$past(ln_a.word)] == $past(mem_par[ln_a.word]);
    endproperty
    a_no_write_disabled: assert property (p_no_write_disabled)
        else $error("port a wrote with enable inactive");

    // output reset loads the configured value on port a
    property p_out_reset;
        @(posedge clk_sys) disable iff (!arst_n)
        (ev_a && en_a && rs_a) |=> q.a == $past(init_val(porta_cfg));
    endproperty
    a_out_reset: assert property (p_out_reset)
        else $error("port a output reset value not loaded");

    // at width 1 only bit 0 of port b read data may be set
    property p_width_one;
        @(posedge clk_sys) disable iff (!arst_n)
        (ev_b && portb_cfg.width == dpr_pkg::DPR_W1)
            |=> q.b.data[31:1] == 31'h0 && q.b.par == 4'h0;
    endproperty
    a_width_one: assert property (p_width_one)
        else $error("port b read data wider than configured");

    // parity written at width 36 is stored unchanged
    property p_parity_stored;
        @(posedge clk_sys) disable iff (!arst_n)
        (wr_a && !wr_b && porta_cfg.width == dpr_pkg::DPR_W36)
            |=> mem_par[$past(ln_a.word)] == $past(in_a.pin);
    endproperty
    a_parity_stored: assert property (p_parity_stored)
        else $error("port a parity not stored as written");

endmodule // dpr_ram

// file: testbench/dpr_user_model.sv
/*
 * user logic on one memory port: drives the port pins with slow port
 * clock phases and returns the read data seen after each active edge.
 * assumes: clk_sys at 100 MHz; the port's polarity setting is INV on
 * all four controls of the port.
 */
module dpr_user_model #(
    parameter bit INV = 1'b0
) (
    input  wire logic                  clk_sys,
    output dpr_pkg::dpr_port_in_t      pins,
    input  wire dpr_pkg::dpr_rd_t      rd
);
    timeunit 1ns;
    timeprecision 1ps;

    ////////////////////////////////////////////////////////////////////////
    // idle pins: port clock at its inactive level, controls inactive
    initial begin
        pins     = '0;
        pins.clk = INV;
        pins.en  = INV;
        pins.we  = INV;
        pins.sync_output_reset = INV;
    end

    ////////////////////////////////////////////////////////////////////////
    // one port edge: setup 4 cycles, high and low phases 4 cycles each
    task automatic access(input logic en,
                          input logic we,
                          input logic rst,
                          input logic [dpr_pkg::ADDR_W-1:0] addr,
                          input dpr_pkg::dpr_rd_t wd,
                          output dpr_pkg::dpr_rd_t q);
        @(posedge clk_sys);
        pins.en <= en ^ INV;
        pins.we <= we ^ INV;
        pins.sync_output_reset <= rst ^ INV;
        pins.addr <= addr;
        pins.din <= wd.data;
        pins.pin <= wd.par;              // parity given as is
        repeat (4) @(posedge clk_sys);
        pins.clk <= ~INV;                // inputs valid before edge
        repeat (4) @(posedge clk_sys);
        pins.clk <= INV;                 // held past the edge
        repeat (4) @(posedge clk_sys);
        q = rd;
        // released enable goes inactive, clock stays at its inactive level; other lines show the inverse of their last value
        pins.en <= INV;
        pins.we <= ~pins.we;
        pins.sync_output_reset <= ~pins.sync_output_reset;
        pins.addr <= ~addr;
        pins.din <= ~wd.data;
        pins.pin <= ~wd.par;
    endtask

endmodule // dpr_user_model

// file: testbench/test_dpr_ram.sv
/*
 * self-checking bench of the dual-port memory: port a plain polarity,
 * port b all controls inverted; every port b width is exercised.
 * assumes: dpr_user_model on each port; memory survives arst_n.
 */
module test_dpr_ram;
    timeunit 1ns;
    timeprecision 1ps;

    logic                   clk_sys;
    logic                   arst_n;
    dpr_pkg::dpr_port_cfg_t porta_cfg;
    dpr_pkg::dpr_port_cfg_t portb_cfg;
    dpr_pkg::dpr_port_in_t  porta_pins;
    dpr_pkg::dpr_port_in_t  portb_pins;
    dpr_pkg::dpr_rd_t       porta_rd;
    dpr_pkg::dpr_rd_t       portb_rd;
    int                     bad_count;
    int                     checks_done;

    dpr_ram dpr_ram_inst (
        .clk_sys    (clk_sys),
        .arst_n     (arst_n),
        .porta_cfg  (porta_cfg),
        .portb_cfg  (portb_cfg),
        .porta_pins (porta_pins),
        .portb_pins (portb_pins),
        .porta_rd   (porta_rd),
        .portb_rd   (portb_rd)
    );
    dpr_user_model #(.INV(1'b0)) user_a (
        .clk_sys (clk_sys),
        .pins    (porta_pins),
        .rd      (porta_rd)
    );
    dpr_user_model #(.INV(1'b1)) user_b (
        .clk_sys (clk_sys),
        .pins    (portb_pins),
        .rd      (portb_rd)
    );

    ////////////////////////////////////////////////////////////////////////
    // compare, verdict and reset with a new port b width
    task automatic chk(input string what,
                       input dpr_pkg::dpr_rd_t exp,
                       input dpr_pkg::dpr_rd_t got);
        checks_done++;
        if (got !== exp) begin
            bad_count++;
            $display("wrong value %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic end_sim();
        if (bad_count == 0 && checks_done > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    task automatic restart(input dpr_pkg::dpr_width_t wb);
        @(posedge clk_sys);
        arst_n <= 1'b0;
        portb_cfg.width <= wb;
        repeat (4) @(posedge clk_sys);
        arst_n <= 1'b1;
        @(posedge clk_sys);
        #1;
        chk("porta_rd reset", '0, porta_rd);
        chk("portb_rd reset", '0, portb_rd);
    endtask

    ////////////////////////////////////////////////////////////////////////
    // clock and watchdog
    initial begin
        clk_sys = 1'b0;
        forever #5 clk_sys = ~clk_sys;
    end

    initial begin
        repeat (20000) @(posedge clk_sys);
        bad_count++;
        end_sim();
    end

    ////////////////////////////////////////////////////////////////////////
    // test sequence
    initial begin
        dpr_pkg::dpr_rd_t       q;
        dpr_pkg::dpr_rd_t       qb;
        dpr_pkg::dpr_rd_t       e;
        logic [63:0]            m;
        logic [dpr_pkg::ADDR_W-1:0] ad;
        int                     db;
        int                     pb;
        int                     n;
        bad_count   = 0;
        checks_done = 0;
        arst_n      = 1'b0;
        porta_cfg   = {4'h0, dpr_pkg::DPR_W36, 32'hA5A5_0F0F, 4'h9};
        portb_cfg   = {4'hF, dpr_pkg::DPR_W36, 32'h3C3C_F0F0, 4'h6};
        repeat (4) @(posedge clk_sys);
        arst_n <= 1'b1;
        // write with parity that does not match the data
        user_a.access(1'b1, 1'b1, 1'b0, 14'h0005, 36'hDEAD_BEEF_A, q);
        user_a.access(1'b1, 1'b0, 1'b0, 14'h0005, '0, q);
        chk("a read", 36'hDEAD_BEEF_A, q);
        user_b.access(1'b1, 1'b0, 1'b0, 14'h0005, '0, q);
        chk("b read shared", 36'hDEAD_BEEF_A, q);
        user_b.access(1'b1, 1'b1, 1'b0, 14'h0005, 36'h1234_5678_3, q);
        chk("b read before write", 36'hDEAD_BEEF_A, q);
        user_a.access(1'b0, 1'b1, 1'b0, 14'h0005, 36'h0BAD_0BAD_C, q);
        chk("a disabled holds", 36'hDEAD_BEEF_A, q);
        user_a.access(1'b1, 1'b0, 1'b1, 14'h0005, '0, q);
        chk("a output reset", 36'hA5A5_0F0F_9, q);
        user_b.access(1'b1, 1'b0, 1'b1, 14'h0005, '0, q);
        chk("b output reset", 36'h3C3C_F0F0_6, q);
        user_b.access(1'b0, 1'b1, 1'b0, 14'h0005, 36'h0BAD_0BAD_C, q);
        chk("b disabled holds", 36'h3C3C_F0F0_6, q);
        user_a.access(1'b1, 1'b0, 1'b0, 14'h0005, '0, q);
        chk("a memory kept", 36'h1234_5678_3, q);
        // both ports write one word on the same edge
        fork
            user_a.access(1'b1, 1'b1, 1'b0, 14'h0009,
                          36'h1111_1111_1, q);
            user_b.access(1'b1, 1'b1, 1'b0, 14'h0009,
                          36'h2222_2222_2, qb);
        join
        user_a.access(1'b1, 1'b0, 1'b0, 14'h0009, '0, q);
        chk("collision", 36'h2222_2222_2, q);
        // every port b width against the top word seen at 36 bits
        for (int w = 0; w < 6; w++) begin
            restart(dpr_pkg::dpr_width_t'(w));
            db = (w < 3) ? (1 << w) : (8 << (w - 3));
            pb = (w < 3) ? 0 : (1 << (w - 3));
            n  = 32 / db;
            ad = 14'((511 * n) + n - 1);
            user_a.access(1'b1, 1'b1, 1'b0, 14'h01FF,
                          36'h0123_4567_5, q);
            m = (64'h1 << db) - 64'h1;
            e.data = (32'h0123_4567 >> ((n - 1) * db)) & m[31:0];
            e.par  = (4'h5 >> ((n - 1) * pb)) & 4'((1 << pb) - 1);
            user_b.access(1'b1, 1'b0, 1'b0, ad, '0, q);
            chk("b lane read", e, q);
            user_b.access(1'b1, 1'b1, 1'b0, ad, '1, q);
            e.data = 32'h0123_4567 | (m[31:0] << ((n - 1) * db));
            e.par  = 4'h5 | (4'((1 << pb) - 1) << ((n - 1) * pb));
            user_a.access(1'b1, 1'b0, 1'b0, 14'h01FF, '0, q);
            chk("a word after lane write", e, q);
        end
        end_sim();
    end

endmodule // test_dpr_ram
